// ===== core/ffo_fifo_core.sv
// Fall-through FIFO core with programmable almost-empty and almost-full offsets
//
`default_nettype none

// Operation
// - Serial shift one bit per edge
// - Twenty bits cover both offsets
// - Almost-empty and almost-full held while programming is busy
// - Serial enable high blocks serial shift
// - Memory writes allowed around programming
// - Paused serial load resumes next bit
// - Almost-full valid two edges after load
// - Almost-empty valid two edges plus skew
// - Offsets read back on parallel port
// - Parallel write steps through four fields
// - Parallel read steps through four fields
// - Method fixed only at master reset
// - Readback in either programming method
// - Empty-side fall-through flag levels
// - Full-side fall-through flag levels
// - Load select at reset picks method
// - Master reset clears offset pointers
// - Master reset loads default offsets
module ffo_fifo_core
(
    // Clocking
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    // Controller pins
    input wire logic master_reset_n_in,
    input wire logic offset_load_select_n_in,
    input wire logic serial_enable_n_in,
    input wire logic write_enable_n_in,
    input wire logic read_enable_n_in,
    input wire logic serial_in,
    input wire logic default_offset_select_0_in,
    input wire logic default_offset_select_1_in,
    input wire logic [ffo_pkg::DATA_W-1:0] data_in,
    // Data and flags
    output logic [ffo_pkg::DATA_W-1:0] data_out,
    output logic input_ready_n_out,
    output logic output_ready_n_out,
    output logic almost_empty_flag_n_out,
    output logic almost_full_flag_n_out,
    output logic half_full_flag_n_out
);
    import ffo_pkg::*;

    // ------------------------------------------------------------
    // Storage and state
    // ------------------------------------------------------------
    logic [DATA_W-1:0] mem [DEPTH];
    logic [ADDR_W-1:0] wr_ptr;
    logic [ADDR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] mem_count;
    logic out_valid;
    logic serial_mode;
    logic prog_busy;
    logic [1:0] afull_wait;
    logic [1:0] aempty_wait;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    wire mreset_act = ~master_reset_n_in;
    wire load_act = ~offset_load_select_n_in;
    wire wen_act = ~write_enable_n_in;
    wire ren_act = ~read_enable_n_in;
    wire ser_en_act = ~serial_enable_n_in;
    // serial shift needs both enables idle
    // no shift unless serial enable is low
    wire serial_shift = !mreset_act && serial_mode && load_act && ser_en_act
        && !wen_act && !ren_act;
    // method bit gates which load path is live
    wire par_write = !mreset_act && !serial_mode && load_act && wen_act
        && !ren_act && !ser_en_act;
    wire par_read = !mreset_act && load_act && ren_act && !wen_act && !ser_en_act;
    // load select high routes enables to memory
    // memory writes stay open around programming
    wire mem_wr_req = !mreset_act && !load_act && wen_act;
    wire mem_rd_req = !mreset_act && !load_act && ren_act;
    wire mem_full = mem_count == MEM_FULL_COUNT;
    wire mem_empty = mem_count == '0;
    wire do_write = mem_wr_req && !mem_full;
    wire consume = mem_rd_req && out_valid;
    // Readback owns the output lines this cycle, so fall-through waits
    wire load_out = !mem_empty && (!out_valid || consume) && !par_read;
    wire next_out_valid = load_out || (out_valid && !consume);
    wire [CNT_W-1:0] total_count = mem_count + {{(CNT_W-1){1'b0}}, out_valid};
    wire [CNT_W-1:0] next_mem_count = mem_count
        + {{(CNT_W-1){1'b0}}, do_write} - {{(CNT_W-1){1'b0}}, load_out};

    // ------------------------------------------------------------
    // Offset registers
    // ------------------------------------------------------------
    wire [OFS_W-1:0] empty_offset;
    wire [OFS_W-1:0] full_offset;
    wire [HALF_W-1:0] ofs_read_field;
    wire ofs_done;
    // default offset from select pins and load select
    wire [OFS_W-1:0] default_value = ffo_default_offset(offset_load_select_n_in,
        default_offset_select_1_in, default_offset_select_0_in);

    ffo_offset_regs u_offset_regs
    (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .clk_en_in(clk_en_in),
        .load_defaults_in(mreset_act),
        .default_value_in(default_value),
        .serial_shift_in(serial_shift),
        .serial_bit_in(serial_in),
        .par_write_in(par_write),
        .par_data_in(data_in[HALF_W-1:0]),
        .par_read_in(par_read),
        .empty_offset_out(empty_offset),
        .full_offset_out(full_offset),
        .read_field_out(ofs_read_field),
        .load_done_out(ofs_done)
    );

    // ------------------------------------------------------------
    // Flag decode
    // ------------------------------------------------------------
    wire next_in_ready_n;
    wire next_out_ready_n;
    wire next_aempty_n;
    wire next_afull_n;
    wire next_hfull_n;

    ffo_flag_decode u_flag_decode
    (
        .word_count_in(total_count),
        .empty_offset_in(empty_offset),
        .full_offset_in(full_offset),
        .next_input_ready_n_out(next_in_ready_n),
        .next_output_ready_n_out(next_out_ready_n),
        .next_almost_empty_n_out(next_aempty_n),
        .next_almost_full_n_out(next_afull_n),
        .next_half_full_n_out(next_hfull_n)
    );

    // programmable flags frozen until the load completes
    wire prog_start = serial_shift || par_write;
    wire next_prog_busy = prog_start && !ofs_done;
    wire afull_valid = !prog_busy && afull_wait == 2'h0;
    wire aempty_valid = !prog_busy && aempty_wait == 2'h0;

    // ------------------------------------------------------------
    // Memory array
    // ------------------------------------------------------------
    // Storage is not reset; only pointers and counts define contents
    always_ff @(posedge core_clk_in)
    begin
        if (clk_en_in && do_write)
            mem[wr_ptr] <= data_in;
    end

    // ------------------------------------------------------------
    // Pointers and method
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            mem_count <= '0;
            out_valid <= 1'b0;
            serial_mode <= RESET_SERIAL_MODE;
        end
        else if (clk_en_in)
        begin
            if (mreset_act)
            begin
                wr_ptr <= '0;
                rd_ptr <= '0;
                mem_count <= '0;
                out_valid <= 1'b0;
                // load select high at reset means serial
                serial_mode <= offset_load_select_n_in;
            end
            else
            begin
                if (do_write)
                    wr_ptr <= wr_ptr + 1'b1;
                if (load_out)
                    rd_ptr <= rd_ptr + 1'b1;
                mem_count <= next_mem_count;
                out_valid <= next_out_valid;
            end
        end
    end

    // ------------------------------------------------------------
    // Settle timers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in || (clk_en_in && mreset_act))
        begin
            prog_busy <= 1'b0;
            afull_wait <= 2'h0;
            aempty_wait <= 2'h0;
        end
        else if (clk_en_in)
        begin
            prog_busy <= prog_start ? next_prog_busy : prog_busy;
            // two further edges before almost-full updates
            // almost-empty waits one extra edge for skew
            if (ofs_done)
            begin
                afull_wait <= AFULL_WAIT_INIT;
                aempty_wait <= AEMPTY_WAIT_INIT;
            end
            else
            begin
                afull_wait <= (afull_wait == 2'h0) ? 2'h0 : afull_wait - 2'h1;
                aempty_wait <= (aempty_wait == 2'h0) ? 2'h0 : aempty_wait - 2'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in || (clk_en_in && mreset_act))
        begin
            data_out <= '0;
            input_ready_n_out <= 1'b0;
            output_ready_n_out <= 1'b1;
            almost_empty_flag_n_out <= 1'b0;
            almost_full_flag_n_out <= 1'b1;
            half_full_flag_n_out <= 1'b1;
        end
        else if (clk_en_in)
        begin
            // offsets only leave through the data port
            // Readback overwrites whatever word was showing
            if (par_read)
                data_out <= {{(DATA_W-HALF_W){1'b0}}, ofs_read_field};
            else if (load_out)
                data_out <= mem[rd_ptr];
            input_ready_n_out <= next_in_ready_n;
            output_ready_n_out <= next_out_ready_n;
            half_full_flag_n_out <= next_hfull_n;
            if (afull_valid)
                almost_full_flag_n_out <= next_afull_n;
            if (aempty_valid)
                almost_empty_flag_n_out <= next_aempty_n;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_serial_en_blocks:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
        (clk_en_in && load_act && serial_enable_n_in && !mreset_act)
        |=> $stable(empty_offset) && $stable(full_offset) || $past(par_write))
    else $error("offsets changed with serial enable high");

    a_prog_freeze:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
        (clk_en_in && prog_busy && !mreset_act)
        |=> $stable(almost_full_flag_n_out) && $stable(almost_empty_flag_n_out))
    else $error("programmable flags moved during offset load");

    a_method_fixed:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
        !mreset_act |=> $stable(serial_mode))
    else $error("programming method changed outside master reset");

    a_strap_capture:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
        (clk_en_in && mreset_act) |=> serial_mode == $past(offset_load_select_n_in))
    else $error("method not taken from load select at reset");

    a_afull_settle:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
        (clk_en_in && ofs_done && !mreset_act) |=> !afull_valid)
    else $error("almost-full updated too soon after load");

    a_aempty_settle:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
        (clk_en_in && ofs_done && !mreset_act) ##1 !mreset_act
        |-> !aempty_valid ##1 !aempty_valid)
    else $error("almost-empty updated too soon after load");

    a_readback_word:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
        (clk_en_in && par_read)
        |=> data_out == {{(DATA_W-HALF_W){1'b0}}, $past(ofs_read_field)})
    else $error("offset readback word wrong");

    a_fall_through_empty:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
        (clk_en_in && !mreset_act && total_count == '0)
        |=> output_ready_n_out && !input_ready_n_out && half_full_flag_n_out)
    else $error("empty flag levels wrong");

    a_fall_through_full:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
        (clk_en_in && !mreset_act && total_count == FULL_COUNT)
        |=> input_ready_n_out && !half_full_flag_n_out && !output_ready_n_out)
    else $error("full flag levels wrong");

    a_mem_write:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
        (clk_en_in && mem_wr_req && !mem_full && !load_out)
        |=> mem_count == $past(mem_count) + 1'b1)
    else $error("memory write not counted");

endmodule : ffo_fifo_core

`default_nettype wire

// ===== core/ffo_pkg.sv
// Constants and default offset table for the flag-offset FIFO core
`default_nettype none

package ffo_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int DATA_W = 36;
    localparam int ADDR_W = 10;
    localparam int DEPTH = 1024;
    localparam int CNT_W = 11;
    localparam int OFS_W = 10;
    localparam int HALF_W = 5;
    localparam int SERIAL_BITS = 2 * OFS_W;
    localparam int SIDX_W = 5;
    localparam logic [SIDX_W-1:0] SERIAL_LAST = 5'h13;
    localparam logic [1:0] LAST_STEP = 2'h3;

    // ------------------------------------------------------------
    // Fall-through word counts
    // ------------------------------------------------------------
    localparam logic [CNT_W-1:0] MEM_FULL_COUNT = 11'h400;
    localparam logic [CNT_W-1:0] FULL_COUNT = 11'h401;
    localparam logic [CNT_W-1:0] HALF_LIMIT = 11'h202;

    // ------------------------------------------------------------
    // Flag settle timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int SKEW_ALLOW_NS = 4;
    localparam int SKEW_RAW = (SKEW_ALLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SKEW_CYCLES = (SKEW_RAW < 1) ? 1 : SKEW_RAW;
    localparam int AFULL_SETTLE = 2;
    localparam int AEMPTY_SETTLE = 2 + SKEW_CYCLES;
    localparam logic [1:0] AFULL_WAIT_INIT = 2'(AFULL_SETTLE - 1);
    localparam logic [1:0] AEMPTY_WAIT_INIT = 2'(AEMPTY_SETTLE - 1);

    // ------------------------------------------------------------
    // Default offsets and reset values
    // ------------------------------------------------------------
    localparam logic [OFS_W-1:0] DEF_OFS_511 = 10'h1FF;
    localparam logic [OFS_W-1:0] DEF_OFS_255 = 10'h0FF;
    localparam logic [OFS_W-1:0] DEF_OFS_127 = 10'h07F;
    localparam logic [OFS_W-1:0] DEF_OFS_63 = 10'h03F;
    localparam logic [OFS_W-1:0] DEF_OFS_31 = 10'h01F;
    localparam logic [OFS_W-1:0] DEF_OFS_15 = 10'h00F;
    localparam logic [OFS_W-1:0] DEF_OFS_7 = 10'h007;
    localparam logic [OFS_W-1:0] DEF_OFS_3 = 10'h003;
    localparam logic RESET_SERIAL_MODE = 1'b1;

    function automatic logic [OFS_W-1:0] ffo_default_offset(input logic load_sel_n,
        input logic sel1, input logic sel0);
        logic [OFS_W-1:0] value;
        case ({load_sel_n, sel1, sel0})
            3'h2: value = DEF_OFS_511;
            3'h1: value = DEF_OFS_255;
            3'h0: value = DEF_OFS_127;
            3'h3: value = DEF_OFS_63;
            3'h4: value = DEF_OFS_31;
            3'h6: value = DEF_OFS_15;
            3'h5: value = DEF_OFS_7;
            default: value = DEF_OFS_3;
        endcase
        return value;
    endfunction : ffo_default_offset

endpackage : ffo_pkg

`default_nettype wire

// ===== core/ffo_offset_regs.sv
// Offset register pair with serial and parallel load and readback pointers
`default_nettype none

module ffo_offset_regs
(
    // Clocking
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    // Load control
    input wire logic load_defaults_in,
    input wire logic [ffo_pkg::OFS_W-1:0] default_value_in,
    input wire logic serial_shift_in,
    input wire logic serial_bit_in,
    input wire logic par_write_in,
    input wire logic [ffo_pkg::HALF_W-1:0] par_data_in,
    input wire logic par_read_in,
    // Results
    output logic [ffo_pkg::OFS_W-1:0] empty_offset_out,
    output logic [ffo_pkg::OFS_W-1:0] full_offset_out,
    output logic [ffo_pkg::HALF_W-1:0] read_field_out,
    output logic load_done_out
);
    import ffo_pkg::*;

    logic [2*OFS_W-1:0] offset_bits;
    logic [SIDX_W-1:0] serial_idx;
    logic [1:0] write_step;
    logic [1:0] read_step;
    wire [2*OFS_W-1:0] next_offset_bits;
    wire serial_last = serial_idx == SERIAL_LAST;
    wire [SIDX_W-1:0] next_serial_idx = serial_last ? '0 : serial_idx + 1'b1;

    // ------------------------------------------------------------
    // Per-bit update
    // ------------------------------------------------------------
    for (genvar i = 0; i < 2 * OFS_W; i++)
    begin : g_bit
        localparam logic [SIDX_W-1:0] BIT_IDX = SIDX_W'(i);
        localparam logic [1:0] STEP = 2'(i / HALF_W);
        // empty offset low half, full offset high half
        assign next_offset_bits[i] = load_defaults_in ? default_value_in[i % OFS_W]
            : (serial_shift_in && serial_idx == BIT_IDX) ? serial_bit_in
            : (par_write_in && write_step == STEP) ? par_data_in[i % HALF_W]
            : offset_bits[i];
    end

    assign empty_offset_out = offset_bits[OFS_W-1:0];
    assign full_offset_out = offset_bits[2*OFS_W-1:OFS_W];
    // readback order follows the read pointer
    assign read_field_out = offset_bits[int'(read_step) * HALF_W +: HALF_W];
    assign load_done_out = (serial_shift_in && serial_last)
        || (par_write_in && write_step == LAST_STEP);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            offset_bits <= {DEF_OFS_127, DEF_OFS_127};
            serial_idx <= '0;
            write_step <= 2'h0;
            read_step <= 2'h0;
        end
        else if (clk_en_in)
        begin
            offset_bits <= next_offset_bits;
            // master reset returns all three pointers to the start
            if (load_defaults_in)
            begin
                serial_idx <= '0;
                write_step <= 2'h0;
                read_step <= 2'h0;
            end
            else
            begin
                // index only moves on a real shift, so pauses resume
                if (serial_shift_in)
                    serial_idx <= next_serial_idx;
                // next five-bit field on each parallel write
                if (par_write_in)
                    write_step <= write_step + 2'h1;
                if (par_read_in)
                    read_step <= read_step + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_serial_advance:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
        (clk_en_in && serial_shift_in && !load_defaults_in && !serial_last)
        |=> serial_idx == $past(serial_idx) + 1'b1)
    else $error("serial index did not advance");

    a_serial_wrap:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
        (clk_en_in && serial_shift_in && !load_defaults_in && serial_last)
        |=> serial_idx == '0 ##0 full_offset_out[OFS_W-1] == $past(serial_bit_in))
    else $error("serial load did not finish at full offset top bit");

    a_par_step:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
        (clk_en_in && par_write_in && !load_defaults_in)
        |=> write_step == $past(write_step) + 2'h1)
    else $error("parallel write pointer did not advance");

    a_mreset_pointers:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
        (clk_en_in && load_defaults_in)
        |=> serial_idx == '0 && write_step == 2'h0 && read_step == 2'h0)
    else $error("pointers not cleared by master reset");

endmodule : ffo_offset_regs

`default_nettype wire

// ===== core/ffo_flag_decode.sv
// Fall-through status flag decode from word count and offsets
`default_nettype none

module ffo_flag_decode
(
    // Inputs
    input wire logic [ffo_pkg::CNT_W-1:0] word_count_in,
    input wire logic [ffo_pkg::OFS_W-1:0] empty_offset_in,
    input wire logic [ffo_pkg::OFS_W-1:0] full_offset_in,
    // Next flag levels, all active low
    output logic next_input_ready_n_out,
    output logic next_output_ready_n_out,
    output logic next_almost_empty_n_out,
    output logic next_almost_full_n_out,
    output logic next_half_full_n_out
);
    import ffo_pkg::*;

    wire [CNT_W-1:0] empty_limit = {1'b0, empty_offset_in} + 11'h001;
    wire [CNT_W-1:0] full_limit = FULL_COUNT - {1'b0, full_offset_in};

    // empty side of the fall-through table
    assign next_output_ready_n_out = word_count_in == '0;
    assign next_almost_empty_n_out = word_count_in > empty_limit;
    // full side of the fall-through table
    assign next_input_ready_n_out = word_count_in == FULL_COUNT;
    assign next_almost_full_n_out = word_count_in < full_limit;
    assign next_half_full_n_out = word_count_in < HALF_LIMIT;

endmodule : ffo_flag_decode

`default_nettype wire

// ===== verif/ffo_ctrl_model.sv
// Controller model driving the FIFO control, serial and data pins
`default_nettype none

module ffo_ctrl_model
    import ffo_pkg::*;
(
    // Clock
    input wire logic core_clk_in,
    // Control pins
    output logic master_reset_n_out,
    output logic offset_load_select_n_out,
    output logic serial_enable_n_out,
    output logic write_enable_n_out,
    output logic read_enable_n_out,
    output logic serial_out,
    output logic [1:0] default_select_out,
    // Data pins
    output logic [DATA_W-1:0] data_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        {master_reset_n_out, offset_load_select_n_out, serial_enable_n_out} = 3'h7;
        {write_enable_n_out, read_enable_n_out, serial_out} = 3'h6;
        default_select_out = 2'h0;
        data_out = 36'h0;
    end

    // Idle lines toggle so stale values never look valid
    task op(input logic load_sel, ser_en, wen, ren, si, input logic [DATA_W-1:0] d);
        @(posedge core_clk_in);
        offset_load_select_n_out <= load_sel;
        serial_enable_n_out <= ser_en;
        write_enable_n_out <= wen;
        read_enable_n_out <= ren;
        serial_out <= ser_en ? ~serial_out : si;
        data_out <= wen ? ~data_out : d;
    endtask : op

    // load select sampled at master reset
    task mreset(input logic load_sel, input logic [1:0] sel);
        @(posedge core_clk_in);
        master_reset_n_out <= 1'b0;
        offset_load_select_n_out <= load_sel;
        default_select_out <= sel;
        op(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 36'h0);
        master_reset_n_out <= 1'b1;
    endtask : mreset

    task serial_load(input logic [SERIAL_BITS-1:0] bits, input logic [DATA_W-1:0] word);
        for (int i = 0; i < SERIAL_BITS; i++)
        begin
            // pause, then one memory write mid-load
            if (i == 10)
            begin
                op(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 36'h0);
                op(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, word);
            end
            op(1'b0, 1'b0, 1'b1, 1'b1, bits[i], 36'h0);
        end
        op(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 36'h0);
    endtask : serial_load

endmodule : ffo_ctrl_model

`default_nettype wire

// ===== verif/fifo_flag_offset_programming_tb_top.sv
// Self-checking bench for the flag-offset FIFO core
`default_nettype none

module fifo_flag_offset_programming_tb_top
    import ffo_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic clk_en = 1'b1;
    wire logic mr_n, lsel_n, ser_en_n, wen_n, ren_n, si;
    wire logic [1:0] sel;
    wire logic [DATA_W-1:0] din;
    logic [DATA_W-1:0] dout;
    logic in_rdy_n, out_rdy_n, aempty_n, afull_n, hfull_n;
    wire logic [4:0] flags = {in_rdy_n, out_rdy_n, aempty_n, afull_n, hfull_n};
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;

    always #4 core_clk_in = ~core_clk_in;

    ffo_ctrl_model ctrl_u (.core_clk_in(core_clk_in), .master_reset_n_out(mr_n),
        .offset_load_select_n_out(lsel_n), .serial_enable_n_out(ser_en_n),
        .write_enable_n_out(wen_n), .read_enable_n_out(ren_n), .serial_out(si),
        .default_select_out(sel), .data_out(din));

    ffo_fifo_core dut_u (.core_clk_in(core_clk_in), .rst_in(rst_in), .clk_en_in(clk_en),
        .master_reset_n_in(mr_n), .offset_load_select_n_in(lsel_n),
        .serial_enable_n_in(ser_en_n), .write_enable_n_in(wen_n), .read_enable_n_in(ren_n),
        .serial_in(si), .default_offset_select_0_in(sel[0]),
        .default_offset_select_1_in(sel[1]), .data_in(din), .data_out(dout),
        .input_ready_n_out(in_rdy_n), .output_ready_n_out(out_rdy_n),
        .almost_empty_flag_n_out(aempty_n), .almost_full_flag_n_out(afull_n),
        .half_full_flag_n_out(hfull_n));

    task complete_run;
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run

    task check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task idle(input int n);
        repeat (n) ctrl_u.op(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 36'h0);
    endtask : idle

    // One offset readback step, sampled after the taking edge
    task rd(input logic [4:0] exp);
        ctrl_u.op(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 36'h0);
        idle(1);
        #1 check(dout, 36'(exp));
    endtask : rd

    task wr_words(input int n, input int first);
        for (int i = 0; i < n; i++)
            ctrl_u.op(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 36'(first + i));
        idle(4);
    endtask : wr_words

    // Hang guard well above the expected run
    always @(posedge core_clk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            complete_run();
        end
    end

    initial
    begin
        repeat (6) @(posedge core_clk_in);
        rst_in <= 1'b0;
        #1 check(36'(flags), 36'h0B);
        ctrl_u.mreset(1'b1, 2'h0);
        rd(5'h1F);
        rd(5'h00);
        rd(5'h1F);
        rd(5'h00);
        $display("test defaults done");
        ctrl_u.serial_load({10'h005, 10'h003}, 36'h1);
        rd(5'h03);
        rd(5'h00);
        rd(5'h05);
        rd(5'h00);
        $display("test serial done");
        wr_words(4, 2);
        #1 check(36'(flags), 36'h07);
        ctrl_u.op(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 36'h0);
        idle(4);
        #1 check(36'(flags), 36'h03);
        check(dout, 36'h2);
        wr_words(1030, 16);
        #1 check(36'(flags), 36'h14);
        $display("test flags done");
        ctrl_u.mreset(1'b0, 2'h2);
        rd(5'h1F);
        rd(5'h0F);
        rd(5'h1F);
        rd(5'h0F);
        for (int i = 0; i < 4; i++)
            ctrl_u.op(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 36'(i == 2 ? 1 : (i == 0) * 2));
        for (int i = 0; i < 6; i++)
            ctrl_u.op(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 36'h0);
        idle(1);
        rd(5'h02);
        rd(5'h00);
        rd(5'h01);
        rd(5'h00);
        // Enable low: readback ignored, pointer must not move
        clk_en <= 1'b0;
        rd(5'h00);
        clk_en <= 1'b1;
        rd(5'h02);
        $display("test parallel done");
        complete_run();
    end

endmodule : fifo_flag_offset_programming_tb_top

`default_nettype wire
